//--- rtl/diag_pkg.sv
// Package of constants for the serial diagnostic interlock status block
package diag_pkg;
    // Chain and timing
    localparam int MAX_CHAIN = 31;
    localparam int CLK_HZ = 10000000;
    localparam int WARN_MINUTES = 30;
    localparam longint WARN_CYCLES_DEF = longint'(WARN_MINUTES) * 60 * CLK_HZ;
    localparam int WARN_CNT_W = 35;
    // Request byte bits
    localparam int REQ_MAGNET = 0;
    localparam int REQ_ERR_RESET = 7;
    // Response byte bits
    localparam int RSP_OUT_ACTIVE = 0;
    localparam int RSP_LOCK_POSSIBLE = 1;
    localparam int RSP_LOCKED = 2;
    localparam int RSP_CHAIN_IN = 4;
    localparam int RSP_ACT_VALID = 5;
    localparam int RSP_WARNING = 6;
    localparam int RSP_ERROR = 7;
    // Detail byte bits
    localparam int DET_OUT_A = 0;
    localparam int DET_OUT_B = 1;
    localparam int DET_CROSS = 2;
    localparam int DET_TEMP = 3;
    localparam int DET_ACTUATOR = 4;
    localparam int DET_INTERNAL = 5;
    localparam int DET_COMM = 6;
    localparam int DET_HANDLE = 7;
    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

//--- rtl/serial_diag_interlock_status.sv
// Request decode, status bytes and fault latching of one chained interlock
`timescale 1ns/1ns
`default_nettype none

module serial_diag_interlock_status
    import diag_pkg::*;
#(
    parameter longint WARN_CYCLES = WARN_CYCLES_DEF,
    parameter bit POWER_TO_LOCK = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Request byte from gateway
    input wire logic [7:0] request_byte,
    input wire logic request_valid,
    // Gateway link health
    input wire logic comm_ok,
    // Serial diagnostic chain pass-through
    input wire logic serial_diag_line_in,
    output logic serial_diag_line_out,
    // Safety chain inputs (asynchronous pins)
    input wire logic chain_input_a,
    input wire logic chain_input_b,
    // Guard and actuator sensing (asynchronous pins)
    input wire logic guard_closed,
    input wire logic actuator_valid,
    input wire logic bolt_locked,
    // Locking turret position (asynchronous pins)
    input wire logic turret_at_rest,
    input wire logic turret_pulled,
    // Warning causes (asynchronous pins)
    input wire logic fault_out_a,
    input wire logic fault_out_b,
    input wire logic fault_cross,
    input wire logic fault_temp,
    // Fault causes (asynchronous pins)
    input wire logic fault_actuator,
    input wire logic fault_internal,
    input wire logic fault_handle,
    // Magnet
    output logic magnet_drive,
    // Safety channels
    output logic safety_output_a,
    output logic safety_output_b,
    // Response byte
    output logic [7:0] response_byte,
    // Detail bytes
    output logic [7:0] warning_detail_byte,
    output logic [7:0] error_detail_byte
);
    // Package constants: bit positions, counts, reset values
    import diag_pkg::*;

    // Number of synchronised pins
    localparam int NSYNC = 14;

    // Whole state of the block in one word
    typedef struct packed {
        // Two-stage pin synchronisers
        logic [NSYNC-1:0] sync1;
        logic [NSYNC-1:0] sync2;
        // Chain relay
        logic serial_q1;
        logic serial_q2;
        // Request state
        logic magnet_on;
        logic reset_req_last;
        // Safety channel state
        logic out_enable;
        logic was_enabled;
        // Fault state
        logic [7:0] err_latch;
        logic [WARN_CNT_W-1:0] warn_cnt;
        // Registered status bytes
        logic [7:0] rsp;
        logic [7:0] wrn;
        logic [7:0] err;
    } state_t;

    // Present and next state
    state_t s_reg;
    state_t s_next;

    // Pin bundle, most significant first
    logic [NSYNC-1:0] pins;
    assign pins = {
        fault_handle,
        fault_internal,
        fault_actuator,
        fault_temp,
        fault_cross,
        fault_out_b,
        fault_out_a,
        turret_pulled,
        turret_at_rest,
        bolt_locked,
        actuator_valid,
        guard_closed,
        chain_input_b,
        chain_input_a
    };

    // Synchronised chain and guard views
    logic in_a;
    logic in_b;
    logic closed;
    logic act_ok;
    logic locked;
    logic at_rest;
    logic pulled;
    // Synchronised fault views
    logic f_a;
    logic f_b;
    logic f_cross;
    logic f_temp;
    logic f_act;
    logic f_int;
    logic f_handle;

    // Unpack from second stage only; first stage may be metastable
    assign {
        f_handle,
        f_int,
        f_act,
        f_temp,
        f_cross,
        f_b,
        f_a,
        pulled,
        at_rest,
        locked,
        act_ok,
        closed,
        in_b,
        in_a
    } = s_reg.sync2;

    // Combinational fault handling and byte assembly
    always_comb begin
        // Scratch values, given defaults first
        logic warn_any;
        logic reset_edge;
        logic [7:0] cause;
        logic [7:0] warn_bits;
        logic lock_ok;
        logic enable_ok;
        warn_any = 1'b0;
        reset_edge = 1'b0;
        cause = BYTE_RESET;
        warn_bits = BYTE_RESET;
        lock_ok = 1'b0;
        enable_ok = 1'b0;
        // Default: every register holds
        s_next = s_reg;

        // Two-flop synchronisers; nothing but the second stage reads the first
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;

        // Chain data re-timed through two stages onto the upstream side;
        // fixed hop delay keeps a full chain's latency bounded
        s_next.serial_q1 = serial_diag_line_in;
        s_next.serial_q2 = s_reg.serial_q1;

        // New request only while link is healthy; else hold state
        // Reset edge needs two accepted requests, 1 then 0
        if (request_valid && comm_ok) begin
            s_next.magnet_on = request_byte[REQ_MAGNET];
            s_next.reset_req_last = request_byte[REQ_ERR_RESET];
            reset_edge = s_reg.reset_req_last && !request_byte[REQ_ERR_RESET];
        end

        // Non-critical warnings, latched only once the timer turns them into a fault
        warn_bits[DET_OUT_A] = f_a;
        warn_bits[DET_OUT_B] = f_b;
        warn_bits[DET_CROSS] = f_cross;
        warn_bits[DET_TEMP] = f_temp;
        // One timer serves all four warning causes
        warn_any = f_a | f_b | f_cross | f_temp;

        // Persistent-warning timer; restarts whenever warnings vanish
        // Saturates at the limit so the converted fault stays set
        if (!warn_any) begin
            s_next.warn_cnt = '0;
        end else if (s_reg.warn_cnt < WARN_CNT_W'(WARN_CYCLES)) begin
            s_next.warn_cnt = s_reg.warn_cnt + WARN_CNT_W'(1);
        end

        // Immediate faults
        cause[DET_ACTUATOR] = f_act;
        cause[DET_INTERNAL] = f_int;
        cause[DET_HANDLE] = f_handle;
        // Warning held too long becomes a fault
        if (s_reg.warn_cnt >= WARN_CNT_W'(WARN_CYCLES)) begin
            cause[3:0] = warn_bits[3:0];
        end

        // Latch: set wins; clear only when cause gone and reset or guard open
        if (reset_edge || !closed) begin
            s_next.err_latch = cause;
            // Output faults survive until the outputs were released again
            if (!s_reg.was_enabled) begin
                s_next.err_latch[1:0] = s_reg.err_latch[1:0] | cause[1:0];
            end
        end else begin
            s_next.err_latch = s_reg.err_latch | cause;
        end
        // Link trouble is a warning only, never latched
        s_next.err_latch[DET_COMM] = 1'b0;

        // Magnet state matching the variant's lock level is a locking request
        if (s_reg.magnet_on == POWER_TO_LOCK) begin
            // Locking allowed only with the turret at rest
            lock_ok = closed && at_rest;
        end else begin
            // Unlocking refused while the door pulls the turret out
            lock_ok = closed && !pulled;
        end

        // Warnings alone leave the channels enabled
        enable_ok = closed && locked && act_ok;
        enable_ok = enable_ok && in_a && in_b;
        enable_ok = enable_ok && (s_next.err_latch == 8'h00);
        s_next.out_enable = enable_ok;

        // Remember a drop of the channels until they are enabled again
        if (s_reg.out_enable && !enable_ok) begin
            s_next.was_enabled = 1'b1;
        end else if (enable_ok) begin
            s_next.was_enabled = 1'b0;
        end

        // Response byte: channel and locking state
        s_next.rsp = BYTE_RESET;
        s_next.rsp[RSP_OUT_ACTIVE] = s_reg.out_enable;
        s_next.rsp[RSP_LOCK_POSSIBLE] = lock_ok;
        s_next.rsp[RSP_LOCKED] = locked && act_ok;

        // Response byte: inputs, actuator, warning and error flags
        s_next.rsp[RSP_CHAIN_IN] = in_a && in_b;
        s_next.rsp[RSP_ACT_VALID] = act_ok;
        s_next.rsp[RSP_WARNING] = warn_any;
        s_next.rsp[RSP_ERROR] = (s_reg.err_latch != 8'h00);

        // Warning detail, kept live so it is ready whenever a flag rises
        s_next.wrn = warn_bits;
        s_next.wrn[DET_INTERNAL] = f_int;
        s_next.wrn[DET_COMM] = !comm_ok;
        s_next.wrn[DET_HANDLE] = f_handle;

        // Error detail trails the latch by one cycle, like the error flag
        s_next.err = s_reg.err_latch;

        // Synchronous reset clears every stage, outputs included
        if (sys_rst) begin
            s_next = '0;
        end
    end

    // Single state register
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    // Chain relay output
    assign serial_diag_line_out = s_reg.serial_q2;

    // Magnet follows the request bit the same way in both variants
    assign magnet_drive = s_reg.magnet_on;

    // Both channels share one register, so they cannot disagree
    assign safety_output_a = s_reg.out_enable;
    assign safety_output_b = s_reg.out_enable;

    // Status bytes straight from flip-flops
    assign response_byte = s_reg.rsp;
    assign warning_detail_byte = s_reg.wrn;
    assign error_detail_byte = s_reg.err;
endmodule // serial_diag_interlock_status

`default_nettype wire

//--- sim/serial_diag_interlock_status_checker.sv
// Port checker of the interlock status block
`timescale 1ns/1ns
`default_nettype none
module serial_diag_interlock_status_checker
    import diag_pkg::*;
(
    // Clock, reset and watched inputs
    input wire logic clk, sys_rst, request_valid, comm_ok, serial_diag_line_in,
    input wire logic [7:0] request_byte,
    input wire logic chain_input_a, fault_internal, fault_temp,
    // Watched outputs
    input wire logic serial_diag_line_out, magnet_drive, safety_output_a, safety_output_b,
    input wire logic [7:0] warning_detail_byte, error_detail_byte
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Relay needs two clean edges after reset, else the pipe still holds zeros
    property p_relay; !$past(sys_rst) && !$past(sys_rst, 2) |->
        serial_diag_line_out == $past(serial_diag_line_in, 2); endproperty
    a_relay: assert property (p_relay) else $error("relay delay");
    property p_twin; safety_output_a == safety_output_b; endproperty
    a_twin: assert property (p_twin) else $error("channels differ");
    property p_mag; request_valid && comm_ok |=>
        magnet_drive == $past(request_byte[REQ_MAGNET]); endproperty
    a_mag: assert property (p_mag) else $error("magnet request");
    property p_hold; !comm_ok |=> $stable(magnet_drive); endproperty
    a_hold: assert property (p_hold) else $error("magnet moved");
    property p_unused; !error_detail_byte[DET_COMM] && !warning_detail_byte[DET_ACTUATOR];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    property p_chain; !chain_input_a [*5] |-> !safety_output_a; endproperty
    a_chain: assert property (p_chain) else $error("output without chain");
    property p_int; fault_internal [*5] |-> !safety_output_a && !safety_output_b; endproperty
    a_int: assert property (p_int) else $error("internal fault");
    property p_warn; fault_temp [*6] |-> warning_detail_byte[DET_TEMP]; endproperty
    a_warn: assert property (p_warn) else $error("warning missing");
endmodule // serial_diag_interlock_status_checker
bind serial_diag_interlock_status serial_diag_interlock_status_checker i_chk (
    .clk(clk), .sys_rst(sys_rst), .request_valid(request_valid), .comm_ok(comm_ok),
    .serial_diag_line_in(serial_diag_line_in), .request_byte(request_byte),
    .chain_input_a(chain_input_a), .fault_internal(fault_internal), .fault_temp(fault_temp),
    .serial_diag_line_out(serial_diag_line_out), .magnet_drive(magnet_drive),
    .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
    .warning_detail_byte(warning_detail_byte), .error_detail_byte(error_detail_byte));
`default_nettype wire

//--- sim/gateway_model.sv
// Gateway model polling one chained interlock
`timescale 1ns/1ns
`default_nettype none
module gateway_model #(parameter int POLL = 4) (
    // Clock, controller side and device side
    input wire logic clk, sys_rst, link_up,
    input wire logic [7:0] out_byte, response_byte,
    output logic [7:0] request_byte, in_byte,
    output logic request_valid, comm_ok
);
    int cnt = 0;
    initial {request_byte, in_byte, request_valid, comm_ok} = '0;
    // One slot every POLL cycles; the byte toggles outside it so stale data never looks valid
    always @(negedge clk) begin
        cnt <= (sys_rst || cnt == POLL - 1) ? 0 : cnt + 1;
        request_valid <= !sys_rst && cnt == 0;
        request_byte <= (cnt == 0) ? out_byte : ~request_byte;
        comm_ok <= link_up;
        if (cnt == 1) in_byte <= response_byte;
    end
endmodule // gateway_model
`default_nettype wire

//--- sim/serial_diag_interlock_status_bench.sv
// Self-checking bench of the interlock status block
`timescale 1ns/1ns
`default_nettype none
`define C(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module serial_diag_interlock_status_bench;
    import diag_pkg::*;
    localparam int WARN = 20;
    logic clk = 1'b1, sys_rst = 1'b1, link_up = 1'b1, sdi = 1'b0;
    logic [7:0] out_byte = 8'h00;
    logic [13:0] p = 14'h0000;
    logic [31:0] lfsr = 32'h745C;
    wire logic [7:0] req, inb, rsp, wdet, edet;
    wire logic rv, cok, sdo, mag, so_a, so_b;
    int errors = 0, checked = 0, mag_m = 0;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Clock and random chain data
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        lfsr <= nxt(lfsr);
        sdi <= lfsr[0];
    end
    gateway_model i_gateway_model (.clk(clk), .sys_rst(sys_rst), .link_up(link_up),
        .out_byte(out_byte), .response_byte(rsp), .request_byte(req), .in_byte(inb),
        .request_valid(rv), .comm_ok(cok));
    serial_diag_interlock_status #(.WARN_CYCLES(WARN)) i_serial_diag_interlock_status (
        .clk(clk), .sys_rst(sys_rst), .request_byte(req), .request_valid(rv), .comm_ok(cok),
        .serial_diag_line_in(sdi), .serial_diag_line_out(sdo), .chain_input_a(p[0]),
        .chain_input_b(p[1]), .guard_closed(p[2]), .actuator_valid(p[3]), .bolt_locked(p[4]),
        .turret_at_rest(p[5]), .turret_pulled(p[6]), .fault_out_a(p[7]), .fault_out_b(p[8]),
        .fault_cross(p[9]), .fault_temp(p[10]), .fault_actuator(p[11]),
        .fault_internal(p[12]), .fault_handle(p[13]), .magnet_drive(mag),
        .safety_output_a(so_a), .safety_output_b(so_b), .response_byte(rsp),
        .warning_detail_byte(wdet), .error_detail_byte(edet));
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Request through the gateway; the model follows only a live link
    task automatic poll(input logic [7:0] b);
        out_byte = b;
        if (link_up) mag_m = b[REQ_MAGNET];
        w(10);
    endtask
    task automatic complete_run();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        errors++;
        complete_run();
    end
    initial begin
        // Two rising edges see reset before it is released
        w(3);
        sys_rst = 1'b0;
        w(2);
        `C("rsp", BYTE_RESET, rsp)
        for (int i = 0; i < 12; i++) begin
            poll(lfsr[8:1]);
            `C("magnet", mag_m[0], mag)
        end
        link_up = 1'b0;
        w(2);
        poll({7'h00, ~mag});
        `C("hold", mag_m[0], mag)
        `C("comm", 1'b1, wdet[DET_COMM])
        link_up = 1'b1;
        p = 14'h003F;
        poll(8'h00);
        `C("rsp", 8'h37, rsp)
        `C("inbyte", 8'h37, inb)
        p[5] = 1'b0;
        w(6);
        `C("rsp", 8'h35, rsp)
        p[6] = 1'b1;
        poll(8'h01);
        `C("magnet", mag_m[0], mag)
        `C("rsp", 8'h35, rsp)
        p[6] = 1'b0;
        w(6);
        `C("rsp", 8'h37, rsp)
        p[5] = 1'b1;
        p[10] = 1'b1;
        w(6);
        `C("out", 1'b1, so_a)
        `C("warn", 1'b1, rsp[RSP_WARNING])
        p[10] = 1'b0;
        w(6);
        `C("warn", 1'b0, rsp[RSP_WARNING])
        p[10] = 1'b1;
        w(WARN + 10);
        `C("out", 1'b0, so_a)
        `C("edet", 1'b1, edet[DET_TEMP])
        p[10] = 1'b0;
        w(6);
        `C("err", 1'b1, rsp[RSP_ERROR])
        poll(8'h80);
        poll(8'h00);
        `C("edet", 8'h00, edet)
        p[11] = 1'b1;
        w(6);
        `C("act", 1'b1, edet[DET_ACTUATOR])
        poll(8'h80);
        poll(8'h00);
        `C("act", 1'b1, edet[DET_ACTUATOR])
        p[11] = 1'b0;
        p[2] = 1'b0;
        w(6);
        `C("edet", 8'h00, edet)
        p[2] = 1'b1;
        p[12] = 1'b1;
        w(6);
        `C("out", 1'b0, so_a)
        complete_run();
    end
endmodule // serial_diag_interlock_status_bench
`default_nettype wire
